//--- design/ddlrc_defines.svh
// constants for the dual dac load and reset control block
`ifndef DDLRC_DEFINES_SVH
`define DDLRC_DEFINES_SVH

`define DDLRC_CMD_WR_INPUT    4'h1
`define DDLRC_CMD_UPD_DAC     4'h2
`define DDLRC_CMD_WR_UPD      4'h3
`define DDLRC_CMD_MASK_LOAD   4'h5
`define DDLRC_CMD_SOFT_RESET  4'h6
`define DDLRC_CMD_REF_SETUP   4'h7
`define DDLRC_CMD_MSB         23
`define DDLRC_CMD_LSB         20
`define DDLRC_ADDR_MSB        19
`define DDLRC_ADDR_LSB        16
`define DDLRC_ADDR_CH_A       0
`define DDLRC_ADDR_CH_B       1
`define DDLRC_DATA_MSB        15
`define DDLRC_DATA_LSB        6
`define DDLRC_MASK_A_BIT      0
`define DDLRC_MASK_B_BIT      3
`define DDLRC_REF_BIT         0
`define DDLRC_MASK_MSB        3
`define DDLRC_MASK_LSB        0
`define DDLRC_MASK_RESET      4'h0
`define DDLRC_REF_RESET       1'h0
`define DDLRC_CODE_ZERO       10'h000
`define DDLRC_CODE_MID        10'h200

`endif

//--- design/ddlrc_pkg.sv
// types for the dual dac load and reset control block
package ddlrc_pkg;
	typedef enum logic [1:0] {
		DDLRC_INIT,
		DDLRC_RUN
	} ddlrc_phase_type;

	typedef struct packed {
		logic [3:0]  cmd;
		logic [3:0]  addr;
		logic [15:0] data;
	} ddlrc_frame_type;

	typedef struct packed {
		logic [9:0] code_a;
		logic [9:0] code_b;
	} ddlrc_codes_type;
endpackage : ddlrc_pkg

//--- design/ddlrc_code_store.sv
// two-entry code store with registered read-out, one entry per channel
`timescale 1ns/10ps
`default_nettype none
module ddlrc_code_store #(
	parameter int WIDTH = 10
) (
	input  wire logic             core_clk,
	input  wire logic             sys_rst,
	input  wire logic [1:0]       wr_en,
	input  wire logic [WIDTH-1:0] wr_data_a,
	input  wire logic [WIDTH-1:0] wr_data_b,
	input  wire logic [WIDTH-1:0] init_code,
	input  wire logic             init_en,
	output logic      [WIDTH-1:0] rd_data_a,
	output logic      [WIDTH-1:0] rd_data_b
);
	typedef struct packed {
		logic [WIDTH-1:0] a;
		logic [WIDTH-1:0] b;
	} ddlrc_store_type;

	ddlrc_store_type st_q;
	ddlrc_store_type st_d;

	always_comb begin
		st_d = st_q;
		if (init_en) begin
			st_d.a = init_code;
			st_d.b = init_code;
		end else begin
			if (wr_en[0]) begin
				st_d.a = wr_data_a;
			end
			if (wr_en[1]) begin
				st_d.b = wr_data_b;
			end
		end
	end

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end

	assign rd_data_a = st_q.a;
	assign rd_data_b = st_q.b;
endmodule : ddlrc_code_store
`default_nettype wire

//--- design/ddlrc_top.sv
// load strobe, mask, reset and reference control for a two-channel dac
// What this block does
// - command 0101 loads mask from DB3..DB0
// - mask load ignores channel address
// - mask bits reset to zero
// - masked channel ignores strobe falling edges
// - mask B at DB3, A at DB0
// - 0001 writes input; dac only if strobe low
// - 0010 copies input to dac register
// - 0011 writes input and dac register
// - strobe falling edge loads unmasked dac registers
// - strobe held low: mask bits ignored
// - reset low clears outputs per level select
// - outputs keep cleared value after reset release
// - no output update while reset low
// - command 0110 returns dac to power-on code
// - strobe ignored during power-on reset
// - initialization waits for reset release
// - power-up zero or midscale by level select
// - outputs hold power-up level until write
// - command 0111 loads reference off bit
// - reference bit resets to zero, on
// - frame is command, msb, lsb bytes
// - 0001 with strobe low updates on frame end
// - deferred update on later strobe falling edge
`timescale 1ns/10ps
`default_nettype none
`include "ddlrc_defines.svh"
module ddlrc_top #(
	parameter int CODE_W = 10
) (
	input  wire logic                     core_clk,
	input  wire logic                     sys_rst,
	input  wire logic                     frame_valid,
	input  wire ddlrc_pkg::ddlrc_frame_type frame,
	input  wire logic                     load_strobe_n,
	input  wire logic                     hw_reset_n,
	input  wire logic                     power_up_level_select,
	output logic      [CODE_W-1:0]        dac_code_a,
	output logic      [CODE_W-1:0]        dac_code_b,
	output logic      [CODE_W-1:0]        input_code_a,
	output logic      [CODE_W-1:0]        input_code_b,
	output logic      [3:0]               load_strobe_mask,
	output logic                          reference_off,
	output logic                          init_done
);
	typedef struct packed {
		logic [1:0]             strobe_sync;
		logic [1:0]             rst_sync;
		logic [1:0]             sel_sync;
		logic                   strobe_prev;
		ddlrc_pkg::ddlrc_phase_type phase;
		logic                   done;
		logic [3:0]             mask;
		logic                   ref_off;
		logic [CODE_W-1:0]      in_a;
		logic [CODE_W-1:0]      in_b;
		logic [CODE_W-1:0]      dac_a;
		logic [CODE_W-1:0]      dac_b;
	} ddlrc_state_type;

	ddlrc_state_type s_q;
	ddlrc_state_type s_d;

	logic [1:0]        dac_wr;
	logic [CODE_W-1:0] dac_wd_a;
	logic [CODE_W-1:0] dac_wd_b;
	logic [CODE_W-1:0] clear_code;
	logic              clear_en;
	logic [CODE_W-1:0] store_a;
	logic [CODE_W-1:0] store_b;
	logic [CODE_W-1:0] wdata;
	logic [1:0]        ch_sel;
	logic              strobe_lvl;
	logic              strobe_fall;
	logic              rst_low;

	// second stages only; first sync stages feed nothing else
	assign strobe_lvl  = s_q.strobe_sync[1];
	assign strobe_fall = s_q.strobe_prev & ~strobe_lvl;
	assign rst_low     = ~s_q.rst_sync[1];
	assign wdata       = frame.data[`DDLRC_DATA_MSB:`DDLRC_DATA_LSB];
	assign ch_sel[0]   = frame.addr[`DDLRC_ADDR_CH_A];
	assign ch_sel[1]   = frame.addr[`DDLRC_ADDR_CH_B];
	assign clear_code  = s_q.sel_sync[1] ? `DDLRC_CODE_MID : `DDLRC_CODE_ZERO;

	always_comb begin
		s_d             = s_q;
		dac_wr          = 2'h0;
		dac_wd_a        = s_q.in_a;
		dac_wd_b        = s_q.in_b;
		clear_en        = 1'b0;
		s_d.strobe_sync = {s_q.strobe_sync[0], load_strobe_n};
		s_d.rst_sync    = {s_q.rst_sync[0], hw_reset_n};
		s_d.sel_sync    = {s_q.sel_sync[0], power_up_level_select};
		s_d.strobe_prev = strobe_lvl;
		// extra stage after the store so the code outputs leave a flop of this module
		s_d.dac_a       = store_a;
		s_d.dac_b       = store_b;
		case (s_q.phase)
			ddlrc_pkg::DDLRC_INIT: begin
				// strobe activity and frames are dropped until reset pin releases
				clear_en = 1'b1;
				s_d.in_a = clear_code;
				s_d.in_b = clear_code;
				if (!rst_low) begin
					s_d.phase = ddlrc_pkg::DDLRC_RUN;
					s_d.done  = 1'h1;
				end
			end
			ddlrc_pkg::DDLRC_RUN: begin
				if (rst_low) begin
					// hold cleared while the pin is low; nothing else is accepted
					clear_en = 1'b1;
					s_d.in_a = clear_code;
					s_d.in_b = clear_code;
				end else begin
					// strobe edge copies input to dac for unmasked channels
					if (strobe_fall) begin
						dac_wr = ~{s_q.mask[`DDLRC_MASK_B_BIT],
							s_q.mask[`DDLRC_MASK_A_BIT]};
					end
					if (frame_valid) begin
						case (frame.cmd)
							`DDLRC_CMD_WR_INPUT: begin
								if (ch_sel[0]) s_d.in_a = wdata;
								if (ch_sel[1]) s_d.in_b = wdata;
								// pin level decides; mask plays no part here
								if (!strobe_lvl) begin
									dac_wr   = dac_wr | ch_sel;
									dac_wd_a = ch_sel[0] ? wdata : s_q.in_a;
									dac_wd_b = ch_sel[1] ? wdata : s_q.in_b;
								end
							end
							`DDLRC_CMD_UPD_DAC: begin
								dac_wr = dac_wr | ch_sel;
							end
							`DDLRC_CMD_WR_UPD: begin
								if (ch_sel[0]) s_d.in_a = wdata;
								if (ch_sel[1]) s_d.in_b = wdata;
								dac_wr   = dac_wr | ch_sel;
								dac_wd_a = ch_sel[0] ? wdata : s_q.in_a;
								dac_wd_b = ch_sel[1] ? wdata : s_q.in_b;
							end
							`DDLRC_CMD_MASK_LOAD: begin
								// address field deliberately not decoded
								s_d.mask = frame.data[`DDLRC_MASK_MSB:`DDLRC_MASK_LSB];
							end
							`DDLRC_CMD_SOFT_RESET: begin
								clear_en    = 1'b1;
								dac_wr      = 2'h0;
								s_d.in_a    = clear_code;
								s_d.in_b    = clear_code;
								s_d.mask    = `DDLRC_MASK_RESET;
								s_d.ref_off = `DDLRC_REF_RESET;
							end
							`DDLRC_CMD_REF_SETUP: begin
								s_d.ref_off = frame.data[`DDLRC_REF_BIT];
							end
							default: begin
							end
						endcase
					end
				end
			end
			default: begin
				s_d.phase = ddlrc_pkg::DDLRC_INIT;
				s_d.done  = 1'h0;
			end
		endcase
	end

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			s_q             <= '0;
			s_q.strobe_sync <= 2'h3;
			s_q.strobe_prev <= 1'b1;
			s_q.phase       <= ddlrc_pkg::DDLRC_INIT;
			s_q.mask        <= `DDLRC_MASK_RESET;
			s_q.ref_off     <= `DDLRC_REF_RESET;
		end else begin
			s_q <= s_d;
		end
	end

	// dac registers live in the store; cleared value held until reprogrammed
	ddlrc_code_store #(
		.WIDTH(CODE_W)
	) u_store (
		.core_clk  (core_clk),
		.sys_rst   (sys_rst),
		.wr_en     (dac_wr),
		.wr_data_a (dac_wd_a),
		.wr_data_b (dac_wd_b),
		.init_code (clear_code),
		.init_en   (clear_en),
		.rd_data_a (store_a),
		.rd_data_b (store_b)
	);

	assign dac_code_a       = s_q.dac_a;
	assign dac_code_b       = s_q.dac_b;
	assign input_code_a     = s_q.in_a;
	assign input_code_b     = s_q.in_b;
	assign load_strobe_mask = s_q.mask;
	assign reference_off    = s_q.ref_off;
	assign init_done        = s_q.done;
endmodule : ddlrc_top
`default_nettype wire

//--- bench/ddlrc_top_assertions.sv
// port assertions for the load strobe and reset control block
`timescale 1ns/10ps
`default_nettype none
module ddlrc_top_chk #(
	parameter int CODE_W = 10
) (
	input wire logic                       core_clk,
	input wire logic                       sys_rst,
	input wire logic                       frame_valid,
	input wire ddlrc_pkg::ddlrc_frame_type frame,
	input wire logic                       load_strobe_n,
	input wire logic                       hw_reset_n,
	input wire logic                       power_up_level_select,
	input wire logic [CODE_W-1:0]          dac_code_a,
	input wire logic [CODE_W-1:0]          dac_code_b,
	input wire logic [CODE_W-1:0]          input_code_a,
	input wire logic [3:0]                 load_strobe_mask,
	input wire logic                       reference_off,
	input wire logic                       init_done
);
	// frames only count once the synchronised reset pin has been high long enough
	logic [2:0]        rst_hist_q;
	logic              acc;
	logic [CODE_W-1:0] clr;
	always_ff @(posedge core_clk) rst_hist_q <= {rst_hist_q[1:0], hw_reset_n};
	assign acc = frame_valid && init_done && (&rst_hist_q);
	assign clr = power_up_level_select ? CODE_W'(10'h200) : '0;
	default clocking @(posedge core_clk); endclocking
	default disable iff (sys_rst);
	mask_load_a: assert property (acc && frame.cmd == 4'h5 |=>
		load_strobe_mask == $past(frame.data[3:0])) else $error("mask load");
	ref_load_a: assert property (acc && frame.cmd == 4'h7 |=>
		reference_off == $past(frame.data[0])) else $error("reference bit");
	input_wr_a: assert property (acc && frame.cmd inside {4'h1, 4'h3} && frame.addr[0] |=>
		input_code_a == $past(frame.data[15:6])) else $error("input write");
	both_wr_a: assert property (acc && frame.cmd == 4'h3 && frame.addr[1] |-> ##2
		dac_code_b == $past(frame.data[15:6], 2)) else $error("write and update");
	soft_rst_a: assert property (acc && frame.cmd == 4'h6 |-> ##2
		dac_code_a == clr && load_strobe_mask == 4'h0) else $error("soft reset");
	hw_clear_a: assert property (!hw_reset_n [*8] |->
		dac_code_a == clr && dac_code_b == clr) else $error("hardware clear");
	init_wait_a: assert property (!init_done && !hw_reset_n |=> !init_done)
		else $error("init early");
	reset_val_a: assert property ($fell(sys_rst) |->
		load_strobe_mask == 4'h0 && !reference_off) else $error("reset values");
	strobe_mask_a: assert property ($fell(load_strobe_n) && load_strobe_mask[0] && !frame_valid
		|=> $stable(dac_code_a) [*6]) else $error("masked strobe");
	strobe_load_a: assert property ($fell(load_strobe_n) && !load_strobe_mask[0] && acc == 1'b0
		&& init_done && (&rst_hist_q) |-> ##[3:5] dac_code_a == input_code_a) else $error("strobe load");
endmodule : ddlrc_top_chk
bind ddlrc_top ddlrc_top_chk #(.CODE_W(CODE_W)) u_ddlrc_top_chk (.*);
`default_nettype wire

//--- bench/ddlrc_ctl_model.sv
// behavioural serial controller handing whole write frames to the block
`timescale 1ns/10ps
`default_nettype none
module ddlrc_ctl_model (
	input  wire logic                       core_clk,
	output var ddlrc_pkg::ddlrc_frame_type frame,
	output var logic                        frame_valid
);
	initial begin
		frame_valid = 1'b0;
		frame = '0;
	end
	// gap stands in for the serial transfer time; idle fields invert so stale data never matches
	task automatic send(input logic [3:0] cmd, input logic [3:0] addr, input logic [15:0] data);
		repeat (8) @(negedge core_clk);
		frame_valid = 1'b1;
		frame = {cmd, addr, data[15:8], data[7:0]};
		@(negedge core_clk);
		frame_valid = 1'b0;
		frame = ~frame;
	endtask : send
endmodule : ddlrc_ctl_model
`default_nettype wire

//--- bench/ddlrc_top_bench.sv
// self-checking bench for the load strobe and reset control block
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin num_errors++; \
	$display("unexpected at %0t: got %h expected %h", $time, a, b); end end
module ddlrc_top_bench;
	logic                       core_clk = 1'b0, sys_rst = 1'b1, load_strobe_n = 1'b1;
	logic                       hw_reset_n = 1'b0, power_up_level_select = 1'b1;
	logic                       frame_valid, reference_off, init_done;
	ddlrc_pkg::ddlrc_frame_type frame;
	logic [9:0]                 dac_code_a, dac_code_b, input_code_a, input_code_b;
	logic [3:0]                 load_strobe_mask;
	int                         num_errors = 0, num_checks = 0, cycles = 0;
	ddlrc_ctl_model u_ddlrc_ctl_model (.core_clk(core_clk), .frame(frame), .frame_valid(frame_valid));
	ddlrc_top u_ddlrc_top (.core_clk(core_clk), .sys_rst(sys_rst), .frame_valid(frame_valid),
		.frame(frame), .load_strobe_n(load_strobe_n), .hw_reset_n(hw_reset_n),
		.power_up_level_select(power_up_level_select), .dac_code_a(dac_code_a),
		.dac_code_b(dac_code_b), .input_code_a(input_code_a), .input_code_b(input_code_b),
		.load_strobe_mask(load_strobe_mask), .reference_off(reference_off), .init_done(init_done));
	always #5 core_clk = ~core_clk;
	always @(posedge core_clk) begin
		cycles++;
		if (cycles == 3000) begin
			num_errors++;
			conclude();
		end
	end
	task automatic tick(input int n);
		repeat (n) @(negedge core_clk);
	endtask : tick
	// code sits in data[15:6], so a code c is sent as c shifted left by six
	task automatic wr(input logic [3:0] c, input logic [3:0] a, input logic [15:0] d);
		u_ddlrc_ctl_model.send(c, a, d);
		tick(2);
	endtask : wr
	task automatic strobe;
		load_strobe_n = 1'b0;
		tick(6);
		load_strobe_n = 1'b1;
		tick(4);
	endtask : strobe
	task automatic t_power_up;
		tick(16);
		sys_rst = 1'b0;
		tick(20);
		`CHK(init_done, 1'b0)
		hw_reset_n = 1'b1;
		tick(6);
		`CHK(init_done, 1'b1)
		`CHK({dac_code_a, dac_code_b}, 20'h80200)
		`CHK({load_strobe_mask, reference_off}, 5'h00)
	endtask : t_power_up
	task automatic t_writes;
		wr(4'h1, 4'h1, 16'h5540);
		`CHK({input_code_a, dac_code_a}, {10'h155, 10'h200})
		strobe();
		`CHK(dac_code_a, 10'h155)
		wr(4'h1, 4'h2, 16'h2A80);
		wr(4'h2, 4'h2, 16'hFFC0);
		`CHK({input_code_b, dac_code_b}, {10'h0AA, 10'h0AA})
		wr(4'h3, 4'h3, 16'hF0C0);
		`CHK({input_code_a, dac_code_b}, {10'h3C3, 10'h3C3})
		load_strobe_n = 1'b0;
		tick(6);
		wr(4'h1, 4'h1, 16'h0440);
		`CHK(dac_code_a, 10'h011)
		load_strobe_n = 1'b1;
	endtask : t_writes
	task automatic t_mask;
		wr(4'h5, 4'h0, 16'h0001);
		`CHK(load_strobe_mask, 4'h1)
		wr(4'h1, 4'h3, 16'h2A80);
		strobe();
		`CHK({dac_code_a, dac_code_b}, {10'h011, 10'h0AA})
		wr(4'h5, 4'hF, 16'h0008);
		`CHK(load_strobe_mask, 4'h8)
		load_strobe_n = 1'b0;
		tick(6);
		wr(4'h1, 4'h2, 16'h0440);
		`CHK({dac_code_a, dac_code_b}, {10'h0AA, 10'h011})
		load_strobe_n = 1'b1;
		wr(4'h7, 4'h0, 16'h0001);
		`CHK(reference_off, 1'b1)
		wr(4'h6, 4'h0, 16'h0000);
		`CHK({dac_code_a, dac_code_b, load_strobe_mask, reference_off}, {20'h80200, 4'h0, 1'b0})
	endtask : t_mask
	task automatic t_hw_reset;
		power_up_level_select = 1'b0;
		tick(4);
		hw_reset_n = 1'b0;
		wr(4'h3, 4'h1, 16'hFFC0);
		`CHK({dac_code_a, dac_code_b, input_code_a}, 30'h0)
		hw_reset_n = 1'b1;
		tick(8);
		`CHK({dac_code_a, dac_code_b}, 20'h0)
	endtask : t_hw_reset
	task automatic conclude;
		$display("checks %0d errors %0d", num_checks, num_errors);
		if (num_errors == 0 && num_checks > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask : conclude
	initial begin
		t_power_up();
		t_writes();
		t_mask();
		t_hw_reset();
		conclude();
	end
endmodule : ddlrc_top_bench
`default_nettype wire
